//--- core/rps_slicer_cfg.sv
/*
 * Per-phase slicer configuration: phase control registers, live slicer
 * threshold with its low-pass filter, and threshold initialisation.
 * Assumes the serial control decoder presents register accesses as
 * single-cycle strobes, and that phase, event and sample inputs are
 * synchronous to ref_clk.
 */
`timescale 1ns/1ns
`include "rps_consts.svh"

// Function
// - wakeup gap limit from wake register bits 7:6
// - code 0 edge, code 1 held level
// - codes 2,3 level slicer with running filter
// - init code 00 starts no load or acquisition of threshold
// - init code 01 loads stored threshold per event
// - init code 10 acquires, result replaces threshold
// - init code 11 also restarts on chip timeout
// - length 0/2/4/8 bits; results update both registers
// - preamble gap and slicer from second register
// - second register init fields cover preamble and data
// - data gap and slicer from third register
// - edge slicer references expected peak register
module rps_slicer_cfg
    import rps_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register access from the serial control decoder
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData_r,
    // receive sequencing
    input wire rps_phase_t rxPhase,
    input wire logic rxEventStart,
    input wire logic chipTimeout,
    // demodulated bit amplitudes
    input wire logic bitValid,
    input wire logic [7:0] bitLevel,
    // slicer settings
    output rps_slicer_t slicerType_r,
    output logic [1:0] gapLimit_r,
    output logic [7:0] sliceThreshold_r,
    output logic [7:0] decisionLevel_r,
    output logic acqActive_r
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0] wakeCtl_r;
    logic [7:0] preCtl_r;
    logic [7:0] dataCtl_r;
    logic [7:0] edgeRef_r;
    logic [7:0] initThr_r;
    logic [7:0] regRdData_nxt;
    logic [1:0] selGap;
    rps_slicer_t selType;
    logic [1:0] selInit;
    logic [1:0] selLen;
    logic [2:0] lpfShift;
    logic signed [8:0] lpfDiff;
    logic signed [8:0] lpfStep;
    logic [8:0] lpfSum;
    logic [7:0] sliceThr_nxt;
    logic acqHit;
    logic initLoad;

    rps_acq_if acqBus ();

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wakeCtl_r <= `RPS_CTL_RST;
            preCtl_r <= `RPS_CTL_RST;
            dataCtl_r <= `RPS_CTL_RST;
            edgeRef_r <= `RPS_EDGE_RST;
        end else if (regWrEn) begin
            case (regAddr)
                `RPS_OFS_WAKE_CTL: wakeCtl_r <= regWrData;
                `RPS_OFS_PRE_CTL: preCtl_r <= regWrData;
                `RPS_OFS_DATA_CTL: dataCtl_r <= regWrData;
                `RPS_OFS_EDGE_REF: edgeRef_r <= regWrData;
                default: ;
            endcase
        end
    end

    // acquisition result beats a software write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            initThr_r <= `RPS_THR_RST;
        end else if (acqHit) begin
            initThr_r <= acqBus.result;
        end else if (regWrEn && regAddr == `RPS_OFS_INIT_THR) begin
            initThr_r <= regWrData;
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    always_comb begin
        case (regAddr)
            `RPS_OFS_WAKE_CTL: regRdData_nxt = wakeCtl_r;
            `RPS_OFS_PRE_CTL: regRdData_nxt = preCtl_r;
            `RPS_OFS_DATA_CTL: regRdData_nxt = dataCtl_r;
            `RPS_OFS_EDGE_REF: regRdData_nxt = edgeRef_r;
            `RPS_OFS_INIT_THR: regRdData_nxt = initThr_r;
            default: regRdData_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            regRdData_r <= 8'h00;
        end else if (regRdEn) begin
            regRdData_r <= regRdData_nxt;
        end
    end

    // ----------------------------------------------------------------
    // phase register set selection
    // ----------------------------------------------------------------
    // idle falls back to the wakeup set, the next phase a receiver enters
    always_comb begin
        case (rxPhase)
            RPS_PH_PRE: begin
                selGap = preCtl_r[`RPS_GAP_HI:`RPS_GAP_LO];
                selType = rps_slicer_t'(preCtl_r[`RPS_SEL_HI:`RPS_SEL_LO]);
                selInit = preCtl_r[`RPS_INIT_HI:`RPS_INIT_LO];
                selLen = preCtl_r[`RPS_ACQ_HI:`RPS_ACQ_LO];
            end
            RPS_PH_DATA: begin
                selGap = dataCtl_r[`RPS_GAP_HI:`RPS_GAP_LO];
                selType = rps_slicer_t'(dataCtl_r[`RPS_SEL_HI:`RPS_SEL_LO]);
                selInit = preCtl_r[`RPS_INIT_HI:`RPS_INIT_LO];
                selLen = preCtl_r[`RPS_ACQ_HI:`RPS_ACQ_LO];
            end
            default: begin
                selGap = wakeCtl_r[`RPS_GAP_HI:`RPS_GAP_LO];
                selType = rps_slicer_t'(wakeCtl_r[`RPS_SEL_HI:`RPS_SEL_LO]);
                selInit = wakeCtl_r[`RPS_INIT_HI:`RPS_INIT_LO];
                selLen = wakeCtl_r[`RPS_ACQ_HI:`RPS_ACQ_LO];
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            slicerType_r <= RPS_SL_EDGE;
            gapLimit_r <= 2'h0;
        end else begin
            slicerType_r <= selType;
            gapLimit_r <= selGap;
        end
    end

    // ----------------------------------------------------------------
    // initial acquisition control
    // ----------------------------------------------------------------
    assign acqBus.start = rxEventStart && selInit[1];
    assign acqBus.restart = chipTimeout && selInit == `RPS_INIT_ACQ_RESTART;
    assign acqBus.stop = (rxPhase == RPS_PH_IDLE);
    assign acqBus.lenCode = selLen;
    assign acqBus.sampleValid = bitValid;
    assign acqBus.sample = bitLevel;

    // a result still counts if the init code changed while it was built
    assign acqHit = acqBus.resultValid;
    assign initLoad = rxEventStart && selInit == `RPS_INIT_LOAD;

    rps_init_acq acqUnit (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .acq(acqBus)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            acqActive_r <= 1'b0;
        end else begin
            acqActive_r <= acqBus.busy;
        end
    end

    // ----------------------------------------------------------------
    // live slicer threshold
    // ----------------------------------------------------------------
    // first-order filter per bit; the shift sets the time constant
    assign lpfShift = (selType == RPS_SL_LPF_FAST) ? `RPS_LPF_SHIFT_FAST
                                                  : `RPS_LPF_SHIFT_SLOW;
    assign lpfDiff = $signed({1'b0, bitLevel}) - $signed({1'b0, sliceThreshold_r});
    assign lpfStep = lpfDiff >>> lpfShift;
    assign lpfSum = {1'b0, sliceThreshold_r} + lpfStep;

    always_comb begin
        sliceThr_nxt = sliceThreshold_r;
        if (acqHit) begin
            sliceThr_nxt = acqBus.result;
        end else if (initLoad) begin
            sliceThr_nxt = initThr_r;
        end else if (bitValid && selType[1]) begin
            sliceThr_nxt = lpfSum[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sliceThreshold_r <= `RPS_THR_RST;
        end else begin
            sliceThreshold_r <= sliceThr_nxt;
        end
    end

    // edge slicer compares against the expected peak, not the threshold
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            decisionLevel_r <= `RPS_EDGE_RST;
        end else if (selType == RPS_SL_EDGE) begin
            decisionLevel_r <= edgeRef_r;
        end else begin
            decisionLevel_r <= sliceThr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence quietThr;
        !acqHit && !initLoad;
    endsequence

    sequence loadRequest;
        rxEventStart && selInit == 2'h1 && !acqHit;
    endsequence

    wake_gap_a: assert property (
        rxPhase == RPS_PH_WAKE |=> gapLimit_r == $past(wakeCtl_r[7:6])
            && slicerType_r == rps_slicer_t'($past(wakeCtl_r[5:4])))
        else $error("wakeup phase did not take wake register fields");

    hold_constant_a: assert property (
        ((selType == RPS_SL_HOLD) and quietThr) |=> $stable(sliceThreshold_r))
        else $error("held slicer threshold moved");

    filter_tracks_a: assert property (
        ((bitValid && selType == RPS_SL_LPF_FAST
            && {1'b0, bitLevel} > {1'b0, sliceThreshold_r} + 9'h001) and quietThr)
        |=> sliceThreshold_r > $past(sliceThreshold_r))
        else $error("fast filter did not move toward the sample");

    never_init_a: assert property (
        selInit == 2'h0 && !acqHit && !(bitValid && selType[1])
        |=> $stable(sliceThreshold_r))
        else $error("threshold changed with initialisation off");

    load_stored_a: assert property (
        loadRequest |=> sliceThreshold_r == $past(initThr_r))
        else $error("stored threshold not loaded at event start");

    acq_result_a: assert property (
        acqHit |=> sliceThreshold_r == $past(acqBus.result)
            && initThr_r == $past(acqBus.result))
        else $error("acquisition result not applied to both thresholds");

    acq_launch_a: assert property (
        chipTimeout && selInit == 2'h3 && selLen != 2'h0 |=> ##1 acqActive_r)
        else $error("chip timeout did not relaunch acquisition");

    preamble_fields_a: assert property (
        rxPhase == RPS_PH_PRE |=> gapLimit_r == $past(preCtl_r[7:6])
            && slicerType_r == rps_slicer_t'($past(preCtl_r[5:4])))
        else $error("preamble phase did not take second register fields");

    data_init_a: assert property (
        rxPhase == RPS_PH_DATA && rxEventStart && preCtl_r[3:2] == 2'h1 && !acqHit
        |=> sliceThreshold_r == $past(initThr_r))
        else $error("data phase ignored second register init code");

    data_fields_a: assert property (
        rxPhase == RPS_PH_DATA |=> gapLimit_r == $past(dataCtl_r[7:6])
            && slicerType_r == rps_slicer_t'($past(dataCtl_r[5:4])))
        else $error("data phase did not take third register fields");

    edge_reference_a: assert property (
        selType == RPS_SL_EDGE |=> decisionLevel_r == $past(edgeRef_r))
        else $error("edge slicer not referenced to expected peak");

    phase_switch_a: assert property (
        rxPhase != $past(rxPhase) && rxPhase == RPS_PH_PRE ##1 1'b1
        |-> gapLimit_r == $past(preCtl_r[7:6]))
        else $error("register set did not follow the phase change");

endmodule

//--- pkg/rps_consts.svh
/*
 * Register offsets, field positions, reset values and filter constants
 * of the receive slicer configuration block.
 * Assumes inclusion by bare name from files that need the numbers.
 */
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RPS_OFS_EDGE_REF 8'h2A
`define RPS_OFS_WAKE_CTL 8'h2B
`define RPS_OFS_PRE_CTL 8'h2C
`define RPS_OFS_DATA_CTL 8'h2D
`define RPS_OFS_INIT_THR 8'h27

// ----------------------------------------------------------------
// field positions inside each phase control register
// ----------------------------------------------------------------
`define RPS_GAP_HI 7
`define RPS_GAP_LO 6
`define RPS_SEL_HI 5
`define RPS_SEL_LO 4
`define RPS_INIT_HI 3
`define RPS_INIT_LO 2
`define RPS_ACQ_HI 1
`define RPS_ACQ_LO 0

// ----------------------------------------------------------------
// threshold initialisation codes
// ----------------------------------------------------------------
`define RPS_INIT_NONE 2'h0
`define RPS_INIT_LOAD 2'h1
`define RPS_INIT_ACQ 2'h2
`define RPS_INIT_ACQ_RESTART 2'h3

// ----------------------------------------------------------------
// reset values and filter shifts
// ----------------------------------------------------------------
`define RPS_CTL_RST 8'h00
`define RPS_EDGE_RST 8'h00
`define RPS_THR_RST 8'h80
`define RPS_LPF_SHIFT_FAST 3'h1
`define RPS_LPF_SHIFT_SLOW 3'h3
`define RPS_ACQ_OFF 2'h0

`endif

//--- pkg/rps_pkg.sv
/*
 * Types shared by the receive slicer configuration modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rps_pkg;

    // receive phase reported by the sequencer
    typedef enum logic [1:0] {
        RPS_PH_IDLE,
        RPS_PH_WAKE,
        RPS_PH_PRE,
        RPS_PH_DATA
    } rps_phase_t;

    // slicer choice, in the order of the two-bit field codes
    typedef enum logic [1:0] {
        RPS_SL_EDGE,
        RPS_SL_HOLD,
        RPS_SL_LPF_FAST,
        RPS_SL_LPF_SLOW
    } rps_slicer_t;

endpackage

//--- pkg/rps_acq_if.sv
/*
 * Carrier between the slicer configuration top and its initial
 * acquisition averager. Both ends run on the same clock.
 */
`timescale 1ns/1ns
interface rps_acq_if;
    logic start;
    logic restart;
    logic stop;
    logic [1:0] lenCode;
    logic sampleValid;
    logic [7:0] sample;
    logic [7:0] result;
    logic resultValid;
    logic busy;

    modport ctl (
        output start, restart, stop, lenCode, sampleValid, sample,
        input result, resultValid, busy
    );
    modport acq (
        input start, restart, stop, lenCode, sampleValid, sample,
        output result, resultValid, busy
    );
endinterface

//--- core/rps_init_acq.sv
/*
 * Initial acquisition averager: sums 2, 4 or 8 bit samples and reports
 * their mean, block after block, while running.
 * Assumes one clock shared with the controlling top module.
 */
`timescale 1ns/1ns
`include "rps_consts.svh"
module rps_init_acq
    import rps_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // control side
    rps_acq_if.acq acq
);

    typedef enum logic {ACQ_IDLE, ACQ_RUN} rps_acq_state_t;

    rps_acq_state_t state_r;
    logic [1:0] len_r;
    logic [2:0] cnt_r;
    logic [10:0] sum_r;
    logic [10:0] sumNxt;
    logic [2:0] lastIdx;
    logic launch;

    // code n averages 2**n samples, so the mean is a right shift by n
    assign launch = (acq.start || acq.restart) && acq.lenCode != `RPS_ACQ_OFF;
    assign sumNxt = sum_r + {3'h0, acq.sample};
    assign lastIdx = 3'((4'h1 << len_r) - 4'h1);

    // ----------------------------------------------------------------
    // run state
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_r <= ACQ_IDLE;
            len_r <= `RPS_ACQ_OFF;
        end else if (launch) begin
            state_r <= ACQ_RUN;
            len_r <= acq.lenCode;
        end else if (acq.stop || acq.start || acq.restart) begin
            state_r <= ACQ_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // accumulation
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cnt_r <= 3'h0;
            sum_r <= 11'h000;
            acq.result <= 8'h00;
            acq.resultValid <= 1'b0;
        end else begin
            acq.resultValid <= 1'b0;
            if (launch || state_r != ACQ_RUN) begin
                cnt_r <= 3'h0;
                sum_r <= 11'h000;
            end else if (acq.sampleValid) begin
                if (cnt_r == lastIdx) begin
                    acq.result <= 8'(sumNxt >> len_r);
                    acq.resultValid <= 1'b1;
                    cnt_r <= 3'h0;
                    sum_r <= 11'h000;
                end else begin
                    cnt_r <= cnt_r + 3'h1;
                    sum_r <= sumNxt;
                end
            end
        end
    end

    assign acq.busy = (state_r == ACQ_RUN);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence twoBitBlock;
        acq.start && acq.lenCode == 2'h1
        ##1 (!acq.sampleValid && !acq.start && !acq.restart && !acq.stop)
        ##1 (acq.sampleValid && !acq.start && !acq.restart && !acq.stop)[*2];
    endsequence

    restart_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acq.restart && acq.lenCode != 2'h0 |=> state_r == ACQ_RUN && cnt_r == 3'h0)
        else $error("restart did not clear the acquisition");

    two_bit_mean_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        twoBitBlock |=> acq.resultValid)
        else $error("two-bit average not reported after two samples");

endmodule

//--- testbench/tb.sv
/*
 * Self-checking bench for the receive slicer configuration block: register
 * access, per-phase field selection, threshold load, filter and acquisition.
 * Assumes the package, interface, constants header and design are compiled first.
 */
`timescale 1ns/1ns
`include "rps_consts.svh"
`define CHK(got, exp, id) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; $display("MISMATCH t=%0t output %0d got %h exp %h", $time, id, got, exp); end end

module tb
    import rps_pkg::*;
();
    // ------------------------------------------------------------
    // design signals
    // ------------------------------------------------------------
    logic ref_clk;
    logic rst_b;
    logic [7:0] regAddr;
    logic regWrEn;
    logic [7:0] regWrData;
    logic regRdEn;
    logic [7:0] regRdData_r;
    rps_phase_t rxPhase;
    logic rxEventStart;
    logic chipTimeout;
    logic bitValid;
    logic [7:0] bitLevel;
    rps_slicer_t slicerType_r;
    logic [1:0] gapLimit_r;
    logic [7:0] sliceThreshold_r;
    logic [7:0] decisionLevel_r;
    logic acqActive_r;

    typedef struct {int sel; logic [7:0] val;} rps_note_t;
    rps_note_t noteQ[$];
    int miscompares = 0;
    int cmp_count = 0;
    rps_phase_t phs[4] = '{RPS_PH_WAKE, RPS_PH_PRE, RPS_PH_DATA, RPS_PH_IDLE};
    int regOfs[4] = '{0, 1, 2, 0};

    rps_slicer_cfg uut (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData_r(regRdData_r),
        .rxPhase(rxPhase), .rxEventStart(rxEventStart), .chipTimeout(chipTimeout),
        .bitValid(bitValid), .bitLevel(bitLevel),
        .slicerType_r(slicerType_r), .gapLimit_r(gapLimit_r),
        .sliceThreshold_r(sliceThreshold_r), .decisionLevel_r(decisionLevel_r),
        .acqActive_r(acqActive_r)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // checker side: notes due now are compared mid-cycle, once settled
    // ------------------------------------------------------------
    always @(negedge ref_clk) begin : mon
        rps_note_t n;
        logic [7:0] got;
        while (noteQ.size() > 0) begin
            n = noteQ.pop_front();
            case (n.sel)
                0: got = regRdData_r;
                1: got = {6'h00, slicerType_r};
                2: got = {6'h00, gapLimit_r};
                3: got = sliceThreshold_r;
                4: got = decisionLevel_r;
                default: got = {7'h00, acqActive_r};
            endcase
            `CHK(got, n.val, n.sel)
        end
    end

    // ------------------------------------------------------------
    // driver tasks, all entered just after a rising edge
    // ------------------------------------------------------------
    task automatic note(input int sel, input logic [7:0] val);
        noteQ.push_back('{sel, val});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        note(0, exp);
        @(posedge ref_clk);
    endtask

    // which=0 receive event start, which=1 chip timeout
    task automatic pulse(input int which);
        if (which == 0) rxEventStart <= 1'b1;
        else chipTimeout <= 1'b1;
        @(posedge ref_clk);
        rxEventStart <= 1'b0;
        chipTimeout <= 1'b0;
    endtask

    // back-to-back samples; caller lets an edge pass before sending again
    task automatic send(input logic [7:0] v[$]);
        foreach (v[i]) begin
            bitValid <= 1'b1;
            bitLevel <= v[i];
            @(posedge ref_clk);
        end
        bitValid <= 1'b0;
    endtask

    // arithmetic shift of the signed difference, as the filter does it
    function automatic logic [7:0] filt(input logic [7:0] t, input logic [7:0] l, input int sh);
        logic signed [9:0] d;
        d = $signed({2'b00, l}) - $signed({2'b00, t});
        return t + 8'(d >>> sh);
    endfunction

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        tick(20000);
        miscompares++;
        $display("MISMATCH t=%0t run limit reached", $time);
        end_sim();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin : main
        logic [7:0] v, e, thr, expd;
        logic [7:0] smp[$];
        logic [7:0] adr[5] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h27};
        int c, sum;
        rst_b = 1'b0;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
        rxPhase = RPS_PH_IDLE;
        rxEventStart = 1'b0;
        chipTimeout = 1'b0;
        bitValid = 1'b0;
        bitLevel = 8'h00;
        v = 8'($urandom(32871));
        tick(2);
        rst_b <= 1'b1;
        tick(2);
        thr = 8'h80;
        note(1, 8'h00);
        note(3, thr);
        note(5, 8'h00);
        foreach (adr[i]) rd(adr[i], (adr[i] == 8'h27) ? 8'h80 : 8'h00);
        rd(8'h30, 8'h00);
        $display("test reset values done");

        foreach (adr[i]) begin
            v = 8'($urandom);
            wr(adr[i], v);
            rd(adr[i], v);
        end
        wr(8'h31, 8'hA5);
        rd(8'h31, 8'h00);
        $display("test register access done");

        e = 8'($urandom);
        wr(8'h2A, e);
        for (int k = 0; k < 4; k++) begin
            wr(8'h2B, {2'(k), 2'(k), 4'h0});
            wr(8'h2C, {2'(k + 1), 2'(k + 1), 4'h0});
            wr(8'h2D, {2'(k + 2), 2'(k + 2), 4'h0});
            foreach (phs[p]) begin
                rxPhase <= phs[p];
                tick(3);
                c = (k + regOfs[p]) % 4;
                note(1, 8'(c));
                if (phs[p] == RPS_PH_PRE) note(2, 8'(c));
                else if (phs[p] == RPS_PH_DATA) note(2, 8'(c));
                else note(2, 8'(c));
                if (c == 0) note(4, e);
                tick(1);
            end
        end
        $display("test phase selection done");

        // held level slicer, load from stored value, then never initialise
        rxPhase <= RPS_PH_WAKE;
        wr(8'h2B, 8'h14);
        v = 8'($urandom);
        wr(8'h27, v);
        pulse(0);
        thr = v;
        note(3, thr);
        smp = '{8'($urandom)};
        send(smp);
        note(3, thr);
        tick(1);
        wr(8'h2B, 8'h10);
        wr(8'h27, ~v);
        pulse(0);
        note(3, thr);
        tick(1);
        $display("test threshold load done");

        for (int code = 2; code < 4; code++) begin
            wr(8'h2B, {2'b00, 2'(code), 4'h0});
            repeat (4) begin
                smp = '{8'($urandom)};
                send(smp);
                thr = filt(thr, smp[0], (code == 2) ? 1 : 3);
                note(3, thr);
                tick(1);
            end
            tick(2);
            note(4, thr);
        end
        $display("test filter done");

        // acquisition in preamble phase, lengths 0, 2, 4 and 8 bits
        rxPhase <= RPS_PH_PRE;
        for (int len = 0; len < 4; len++) begin
            wr(8'h2C, {4'h1, 2'b10, 2'(len)});
            pulse(0);
            tick(1);
            note(5, (len != 0) ? 8'h01 : 8'h00);
            smp = {};
            sum = 0;
            for (int i = 0; i < (1 << len) && len != 0; i++) begin
                smp.push_back(8'($urandom));
                sum += smp[i];
            end
            send(smp);
            tick(3);
            if (len != 0) thr = 8'(sum >> len);
            note(3, thr);
            rd(8'h27, (len != 0) ? thr : ~v);
        end
        $display("test acquisition done");

        // data phase uses second register init fields; timeout restart only for code 11
        wr(8'h2D, 8'h10);
        rxPhase <= RPS_PH_DATA;
        for (int code = 2; code < 4; code++) begin
            wr(8'h2C, {4'h1, 2'(code), 2'b10});
            pulse(0);
            tick(1);
            smp = '{8'($urandom), 8'($urandom)};
            send(smp);
            pulse(1);
            for (int i = 0; i < 4; i++) smp.push_back(8'($urandom));
            expd = (code == 3) ? 8'((10'(smp[2]) + smp[3] + smp[4] + smp[5]) >> 2)
                               : 8'((10'(smp[0]) + smp[1] + smp[2] + smp[3]) >> 2);
            smp = smp[2:5];
            send(smp);
            tick(3);
            note(3, expd);
            rd(8'h27, expd);
        end
        wr(8'h2C, 8'h14);
        wr(8'h27, e);
        pulse(0);
        note(3, e);
        tick(1);
        rxPhase <= RPS_PH_IDLE;
        $display("test restart done");
        tick(3);
        end_sim();
    end
endmodule
